// ==== hw/aoi_regs.svh ====
// register map, field positions and reset values of the axis interlock
// assumes a 32-bit AHB-Lite slave port and one 20 MHz clock
`ifndef AOI_REGS_SVH
`define AOI_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define AOI_OFS_CTRL 8'h00
`define AOI_OFS_CFG 8'h04
`define AOI_OFS_STATUS 8'h08
`define AOI_OFS_ALARM 8'h0C
`define AOI_OFS_IRQSTAT 8'h10
`define AOI_OFS_IRQMASK 8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define AOI_CTRL_RAMP 0
`define AOI_CTRL_COAST 1
`define AOI_CTRL_FAST 2
`define AOI_CTRL_ENABLE 3
`define AOI_CTRL_ACK 4
`define AOI_CTRL_START 5
`define AOI_ST_FAULT 1
`define AOI_ST_INOP 2
`define AOI_ST_TRAV 3
`define AOI_ST_PULSE 4
`define AOI_ST_CODE_LO 8
`define AOI_CFG_RAMP_LO 8
`define AOI_AL_ABSENT 0
`define AOI_AL_REFUSED 1
`define AOI_AL_RAMP 2
`define AOI_AL_COAST 3
`define AOI_AL_FAST 4
`define AOI_AL_ENABLE 5

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define AOI_CTRL_RST 4'h0
`define AOI_AXIS_ABSENT 8'h00
`define AOI_RAMP_RST 16'h0064
`define AOI_MS_CYCLES 20000

`endif

// ==== hw/aoi_pkg.sv ====
// types shared by the axis interlock modules
// assumes aoi_regs.svh is included by the modules that use it
package aoi_pkg;

  // control signals issued by the controller
  typedef struct packed {
    logic ctrlEnable;
    logic fastStop;
    logic coastStop;
    logic rampStop;
  } aoi_stopreq_t;

  // pin inputs after synchronising
  typedef struct packed {
    logic [7:0] faultCode;
    logic fault;
    logic standstill;
    logic travDone;
    logic fastChk;
    logic coastChk;
  } aoi_pins_t;

  // latched AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } aoi_aphase_t;

  typedef enum logic [2:0] {
    AOI_IDLE = 3'b000,
    AOI_TRAVERSE = 3'b001,
    AOI_RAMP = 3'b010,
    AOI_CURLIM = 3'b011,
    AOI_PULSEOFF = 3'b100
  } aoi_state_t;

  typedef enum logic [1:0] {
    AOI_DEC_NONE = 2'b00,
    AOI_DEC_RAMP = 2'b01,
    AOI_DEC_CURLIM = 2'b10
  } aoi_decel_t;

endpackage : aoi_pkg

// ==== hw/aoi_ramp_timer.sv ====
// ramp deceleration timer, counts whole milliseconds
// assumes start is a one-cycle pulse and abort clears a running ramp
`timescale 1ns/10ps
`default_nettype none
module aoi_ramp_timer
  import aoi_pkg::*;
#(
  parameter int MS_CYCLES = 20000
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] rampMs,
  output logic done
);

  logic [14:0] preQ;
  logic [15:0] msLeftQ;
  logic runQ;
  wire msTick = (preQ == 15'(MS_CYCLES - 1));
  wire lastMs = (msLeftQ <= 16'h0001);

  // ----------------------------------------------------------------------
  // prescaler and millisecond down counter
  // ----------------------------------------------------------------------
  // a zero ramp still lasts one millisecond, never a zero-length ramp
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      preQ <= 15'h0000;
      msLeftQ <= 16'h0000;
      runQ <= 1'b0;
    end else if (abort) begin
      runQ <= 1'b0;
      preQ <= 15'h0000;
    end else if (start) begin
      runQ <= 1'b1;
      preQ <= 15'h0000;
      msLeftQ <= rampMs;
    end else if (runQ) begin
      preQ <= msTick ? 15'h0000 : preQ + 15'h0001;
      if (msTick) begin
        msLeftQ <= msLeftQ - 16'h0001;
        if (lastMs) runQ <= 1'b0;
      end
    end
  end

  assign done = runQ & msTick & lastMs & ~abort;

endmodule // aoi_ramp_timer
`default_nettype wire

// ==== hw/aoi_axis_interlock.sv ====
// interlock and alarm logic for one positioning axis
// assumes an AHB-Lite master on sys_clk and drive checkbacks from outside
`timescale 1ns/10ps
`default_nettype none
`include "aoi_regs.svh"
module aoi_axis_interlock
  import aoi_pkg::*;
#(
  parameter int MS_CYCLES = `AOI_MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // drive side pins
  input wire logic coastChkIn,
  input wire logic fastChkIn,
  input wire logic travDoneIn,
  input wire logic standstillIn,
  input wire logic faultIn,
  input wire logic [7:0] faultCodeIn,
  output logic pulseEnable,
  output logic posCtrlEnable,
  output logic traverseActive,
  output logic [1:0] decelMode,
  output logic irq
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  aoi_pins_t pinMetaQ, pinQ;
  wire aoi_pins_t pinRaw = '{faultCode: faultCodeIn, fault: faultIn,
                             standstill: standstillIn, travDone: travDoneIn,
                             fastChk: fastChkIn, coastChk: coastChkIn};

  // code runs through the same two stages as the fault level, sampled every cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMetaQ <= '0;
      pinQ <= '0;
    end else begin
      pinMetaQ <= pinRaw;
      pinQ <= pinMetaQ;
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite address phase and decode
  // ----------------------------------------------------------------------
  aoi_aphase_t aphQ;
  wire addrTaken = hsel & htrans[1] & hready;
  wire wrData = aphQ.valid & aphQ.write;

  function automatic logic hit(input aoi_aphase_t a, input logic [7:0] ofs);
    hit = a.valid & a.write & (a.addr == ofs);
  endfunction

  wire wrCtrl = hit(aphQ, `AOI_OFS_CTRL);
  wire wrCfg = hit(aphQ, `AOI_OFS_CFG);
  wire wrIrqStat = hit(aphQ, `AOI_OFS_IRQSTAT);
  wire wrIrqMask = hit(aphQ, `AOI_OFS_IRQMASK);

  // zero wait states, every transfer answered OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) aphQ <= '0;
    else aphQ <= '{valid: addrTaken, write: hwrite, addr: haddr[7:0]};
  end

  // ----------------------------------------------------------------------
  // control and configuration registers
  // ----------------------------------------------------------------------
  aoi_stopreq_t reqQ;
  logic [7:0] axisTypeQ;
  logic [15:0] rampMsQ;
  logic ackPulseQ, startPulseQ;

  // ack and start are write strobes, they read back as zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reqQ <= `AOI_CTRL_RST;
      ackPulseQ <= 1'b0;
      startPulseQ <= 1'b0;
    end else begin
      ackPulseQ <= wrCtrl & hwdata[`AOI_CTRL_ACK];
      startPulseQ <= wrCtrl & hwdata[`AOI_CTRL_START];
      if (wrCtrl) reqQ <= hwdata[`AOI_CTRL_ENABLE:`AOI_CTRL_RAMP];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      axisTypeQ <= `AOI_AXIS_ABSENT;
      rampMsQ <= `AOI_RAMP_RST;
    end else if (wrCfg) begin
      axisTypeQ <= hwdata[7:0];
      rampMsQ <= hwdata[`AOI_CFG_RAMP_LO +: 16];
    end
  end

  // ----------------------------------------------------------------------
  // fault latch
  // ----------------------------------------------------------------------
  logic faultQ;
  logic [7:0] faultCodeQ;
  wire faultClr = ackPulseQ & ~pinQ.fault; // cause must be gone first

  // a new fault in the acknowledge cycle wins over the clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      faultQ <= 1'b0;
      faultCodeQ <= 8'h00;
    end else if (pinQ.fault) begin
      faultQ <= 1'b1;
      if (!faultQ) faultCodeQ <= pinQ.faultCode;
    end else if (faultClr) begin
      faultQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // in-operation condition
  // ----------------------------------------------------------------------
  logic inOpQ, armedQ, rampPrevQ;
  wire axisAbsent = (axisTypeQ == `AOI_AXIS_ABSENT);
  wire ctrlAllOn = reqQ.rampStop & reqQ.coastStop & reqQ.fastStop
                   & reqQ.ctrlEnable;
  wire chkAllOn = pinQ.coastChk & pinQ.fastChk;
  wire condOk = ctrlAllOn & chkAllOn & ~faultQ & ~axisAbsent;
  wire rampRise = reqQ.rampStop & ~rampPrevQ;
  wire inOpD = condOk & (armedQ | rampRise);
  wire inOpLost = inOpQ & ~inOpD;

  // re-arm needs a fresh off-then-on of the ramp stop request; a rise in the
  // same cycle as a loss still re-arms
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      inOpQ <= 1'b0;
      armedQ <= 1'b0;
      rampPrevQ <= 1'b0;
    end else begin
      rampPrevQ <= reqQ.rampStop;
      inOpQ <= inOpD;
      if (rampRise) armedQ <= 1'b1;
      else if (inOpLost) armedQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // stop reaction decode
  // ----------------------------------------------------------------------
  wire coastLost = ~reqQ.coastStop | ~pinQ.coastChk;
  wire fastLost = ~reqQ.fastStop | ~pinQ.fastChk;
  wire enableLost = ~reqQ.ctrlEnable;
  wire rampLost = ~reqQ.rampStop;
  // faults or axis removal also take the pulses away at once
  wire pulseOffNow = coastLost | enableLost | faultQ | axisAbsent;
  wire curLimNow = fastLost & ~pulseOffNow;
  wire rampNow = rampLost & ~pulseOffNow & ~fastLost;

  // ----------------------------------------------------------------------
  // traversing state machine
  // ----------------------------------------------------------------------
  aoi_state_t stateQ, stateD;
  wire rampDone;
  wire startOk = startPulseQ & inOpQ & ~axisAbsent;
  wire startRefused = startPulseQ & ~startOk;
  wire inTrav = (stateQ == AOI_TRAVERSE);
  wire inRamp = (stateQ == AOI_RAMP);
  wire enterRamp = inTrav & rampNow;

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      AOI_IDLE: begin
        if (startOk) stateD = AOI_TRAVERSE;
      end
      AOI_TRAVERSE: begin
        if (pulseOffNow) stateD = AOI_PULSEOFF;
        else if (curLimNow) stateD = AOI_CURLIM;
        else if (rampNow) stateD = AOI_RAMP;
        else if (pinQ.travDone) stateD = AOI_IDLE;
      end
      AOI_RAMP: begin
        if (pulseOffNow) stateD = AOI_PULSEOFF;
        else if (curLimNow) stateD = AOI_CURLIM;
        else if (rampDone) stateD = AOI_PULSEOFF;
      end
      AOI_CURLIM: begin
        if (pulseOffNow) stateD = AOI_PULSEOFF;
        else if (pinQ.standstill) stateD = AOI_PULSEOFF;
      end
      AOI_PULSEOFF: begin
        stateD = AOI_IDLE;
      end
      default: begin
        stateD = AOI_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) stateQ <= AOI_IDLE;
    else stateQ <= stateD;
  end

  // ramp length comes from the configured deceleration time
  aoi_ramp_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_ramp (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(enterRamp),
    .abort(inRamp & (pulseOffNow | curLimNow)),
    .rampMs(rampMsQ),
    .done(rampDone)
  );

  // ----------------------------------------------------------------------
  // drive outputs
  // ----------------------------------------------------------------------
  logic pulseEnQ, posCtrlQ, travQ;
  logic [1:0] decelQ;
  wire pulseEnD = (stateD == AOI_TRAVERSE) | (stateD == AOI_RAMP)
                  | (stateD == AOI_CURLIM) | ((stateD == AOI_IDLE) & inOpD);
  wire [1:0] decelD = (stateD == AOI_RAMP) ? AOI_DEC_RAMP :
                      (stateD == AOI_CURLIM) ? AOI_DEC_CURLIM : AOI_DEC_NONE;

  // pulses drop in the same cycle as the state leaves motion
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulseEnQ <= 1'b0;
      posCtrlQ <= 1'b0;
      travQ <= 1'b0;
      decelQ <= AOI_DEC_NONE;
    end else begin
      pulseEnQ <= pulseEnD & ~axisAbsent;
      posCtrlQ <= pulseEnD & ~axisAbsent;
      travQ <= (stateD == AOI_TRAVERSE);
      decelQ <= decelD;
    end
  end

  assign pulseEnable = pulseEnQ;
  assign posCtrlEnable = posCtrlQ;
  assign traverseActive = travQ;
  assign decelMode = decelQ;

  // ----------------------------------------------------------------------
  // alarm flags
  // ----------------------------------------------------------------------
  logic [5:0] alarmQ;
  wire recovered = inOpD & ~inOpQ; // in_operation regained
  wire [5:0] alarmSet = {inTrav & enableLost,
                         inTrav & fastLost & ~pulseOffNow,
                         inTrav & coastLost,
                         inTrav & rampLost & ~pulseOffNow & ~fastLost,
                         startRefused,
                         1'b0};

  // movement alarms hold until in_operation returns; set wins on a tie
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarmQ <= 6'h00;
    end else begin
      alarmQ[`AOI_AL_ABSENT] <= axisAbsent;
      alarmQ[5:1] <= alarmSet[5:1] | (alarmQ[5:1] & ~{5{recovered}});
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------------
  logic [5:0] alarmPrevQ, irqStatQ, irqMaskQ;
  wire [5:0] alarmRise = alarmQ & ~alarmPrevQ;
  wire [5:0] w1c = wrIrqStat ? hwdata[5:0] : 6'h00;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarmPrevQ <= 6'h00;
      irqStatQ <= 6'h00;
      irqMaskQ <= 6'h00;
    end else begin
      alarmPrevQ <= alarmQ;
      irqStatQ <= alarmRise | (irqStatQ & ~w1c);
      if (wrIrqMask) irqMaskQ <= hwdata[5:0];
    end
  end

  assign irq = |(irqStatQ & irqMaskQ);

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [31:0] statusWord, rdMux;
  logic [31:0] rdataQ;
  wire aphRead = addrTaken & ~hwrite;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`AOI_ST_FAULT] = faultQ;
    statusWord[`AOI_ST_INOP] = inOpQ;
    statusWord[`AOI_ST_TRAV] = travQ;
    statusWord[`AOI_ST_PULSE] = pulseEnQ;
    statusWord[`AOI_ST_CODE_LO +: 8] = faultCodeQ;
  end

  always_comb begin
    case (haddr[7:0])
      `AOI_OFS_CTRL: rdMux = {28'h000_0000, reqQ};
      `AOI_OFS_CFG: rdMux = {8'h00, rampMsQ, axisTypeQ};
      `AOI_OFS_STATUS: rdMux = statusWord;
      `AOI_OFS_ALARM: rdMux = {26'h000_0000, alarmQ};
      `AOI_OFS_IRQSTAT: rdMux = {26'h000_0000, irqStatQ};
      `AOI_OFS_IRQMASK: rdMux = {26'h000_0000, irqMaskQ};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // sampled at the address phase so data stand through the data phase
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) rdataQ <= 32'h0000_0000;
    else if (aphRead) rdataQ <= rdMux;
  end

  assign hrdata = rdataQ;

  // writes are decoded only in their own data phase
  wire unusedBits = ^{haddr[31:8], haddr[1:0], hsize, wrData, hwdata[31:24]};

endmodule // aoi_axis_interlock
`default_nettype wire

// ==== test/aoi_drive_model.sv ====
// drive-side model: checkbacks, fault pins and standstill for the interlock
// assumes the bench requests checkback and fault levels on sys_clk
`timescale 1ns/10ps
`default_nettype none
module aoi_drive_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [1:0] decelMode,
  input wire logic coastOk,
  input wire logic fastOk,
  input wire logic faultReq,
  input wire logic [7:0] faultNum,
  input wire logic [3:0] stopDelay,
  output logic coastChkIn,
  output logic fastChkIn,
  output logic standstillIn,
  output logic faultIn,
  output logic [7:0] faultCodeIn
);
  logic [3:0] stopCnt_q;

  // ----------------------------------------------------------------------
  // pin behaviour
  // ----------------------------------------------------------------------
  // the code toggles while no fault so a stale number never looks valid
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      coastChkIn <= 1'b0;
      fastChkIn <= 1'b0;
      faultIn <= 1'b0;
      faultCodeIn <= 8'h00;
      stopCnt_q <= 4'h0;
      standstillIn <= 1'b0;
    end else begin
      coastChkIn <= coastOk;
      fastChkIn <= fastOk;
      faultIn <= faultReq;
      faultCodeIn <= faultReq ? faultNum : ~faultCodeIn;
      stopCnt_q <= (decelMode == 2'b10 && stopCnt_q != 4'hF) ? stopCnt_q + 4'h1 : 4'h0;
      standstillIn <= (decelMode == 2'b10) && (stopCnt_q >= stopDelay); // motor stops late
    end
  end
endmodule // aoi_drive_model
`default_nettype wire

// ==== test/aoi_axis_interlock_sva.sv ====
// checker for the axis interlock stop reactions and bus answer
// assumes it is bound to aoi_axis_interlock and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module aoi_axis_interlock_sva
  import aoi_pkg::*;
#(
  parameter int MS_CYCLES = 20000
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic coastChkIn,
  input wire logic fastChkIn,
  input wire logic standstillIn,
  input wire logic faultIn,
  input wire logic pulseEnable,
  input wire logic posCtrlEnable,
  input wire logic traverseActive,
  input wire logic [1:0] decelMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------------
  // two sync stages plus one register, two cycles slack
  sequence cutSoon;
    ##[1:5] !pulseEnable;
  endsequence

  ready_always_a: assert property (hreadyout) else $error("slave inserted a wait");
  resp_okay_a: assert property (!hresp) else $error("slave answered an error");
  coast_cut_a: assert property ($fell(coastChkIn) && traverseActive |-> cutSoon)
    else $error("pulses kept after coast checkback loss");
  fault_cut_a: assert property ($rose(faultIn) && traverseActive |-> cutSoon)
    else $error("pulses kept after fault");
  fast_stop_a: assert property ($fell(fastChkIn) && coastChkIn && traverseActive
    |-> ##[1:5] (decelMode == 2'b10 || !pulseEnable)) else $error("no current limit stop");
  standstill_off_a: assert property (decelMode == 2'b10 && standstillIn |-> cutSoon)
    else $error("pulses kept at standstill");
  no_deescalate_a: assert property (decelMode == 2'b10 |=> decelMode != 2'b01)
    else $error("current limit stop fell back to ramp");
  ramp_pulses_a: assert property ($rose(decelMode == 2'b01) |-> pulseEnable)
    else $error("ramp started without pulses");
  reset_quiet_a: assert property ($rose(arst_n) |-> !pulseEnable && !posCtrlEnable)
    else $error("axis active straight after reset");
endmodule // aoi_axis_interlock_sva

bind aoi_axis_interlock aoi_axis_interlock_sva #(.MS_CYCLES(MS_CYCLES)) sva (
  .sys_clk(sys_clk), .arst_n(arst_n), .hreadyout(hreadyout), .hresp(hresp),
  .coastChkIn(coastChkIn), .fastChkIn(fastChkIn), .standstillIn(standstillIn),
  .faultIn(faultIn), .pulseEnable(pulseEnable), .posCtrlEnable(posCtrlEnable),
  .traverseActive(traverseActive), .decelMode(decelMode));
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the axis interlock over AHB-Lite
// assumes aoi_drive_model on the drive pins and a 20 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "aoi_regs.svh"
module tb_top
  import aoi_pkg::*;
;
  logic sys_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, decelMode;
  logic [2:0] hsize;
  logic coastChkIn, fastChkIn, standstillIn, faultIn, pulseEnable, posCtrlEnable;
  logic traverseActive, irq, coastOk, fastOk, faultReq, travDone;
  logic [7:0] faultCodeIn, faultNum;
  logic [3:0] stopDelay;
  int nErrors, checked, axisM;
  int alTab[8] = '{4, 8, 16, 32, 8, 16, 0, 16};
  int dmTab[8] = '{1, 0, 2, 0, 0, 2, 0, 2};
  int ctTab[8] = '{14, 13, 11, 7, 15, 15, 15, 10};
  assign hready = hreadyout;

  aoi_axis_interlock #(.MS_CYCLES(10)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .coastChkIn(coastChkIn), .fastChkIn(fastChkIn), .travDoneIn(travDone),
    .standstillIn(standstillIn), .faultIn(faultIn), .faultCodeIn(faultCodeIn),
    .pulseEnable(pulseEnable), .posCtrlEnable(posCtrlEnable),
    .traverseActive(traverseActive), .decelMode(decelMode), .irq(irq));
  aoi_drive_model drv (.sys_clk(sys_clk), .arst_n(arst_n), .decelMode(decelMode),
    .coastOk(coastOk), .fastOk(fastOk), .faultReq(faultReq), .faultNum(faultNum),
    .stopDelay(stopDelay), .coastChkIn(coastChkIn), .fastChkIn(fastChkIn),
    .standstillIn(standstillIn), .faultIn(faultIn), .faultCodeIn(faultCodeIn));

  // ----------------------------------------------------------------------
  // bus tasks, model and compares
  // ----------------------------------------------------------------------
  // master waits on hready rather than assuming zero wait states
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic chkReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    checked++;
    if ((r & m) !== e) begin
      nErrors++;
      $display("BAD %0t reg %h read %h want %h", $time, a, r & m, e);
    end
  endtask

  // pin order: pulse, traverse, decel[1:0], position control, irq
  task automatic chkPin(input logic [5:0] e, input logic [5:0] m);
    logic [5:0] p;
    p = {pulseEnable, traverseActive, decelMode, posCtrlEnable, irq};
    checked++;
    if ((p & m) !== (e & m)) begin
      nErrors++;
      $display("BAD %0t pins %b want %b", $time, p & m, e & m);
    end
  endtask

  function automatic int expInop(int ctrl, int chk, int flt, int axis, int armed);
    return (ctrl == 15 && chk != 0 && flt == 0 && axis != 0 && armed != 0) ? 4 : 0;
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // watchdog sized well above the roughly 700 cycles of the run
  initial begin
    repeat (20000) @(posedge sys_clk);
    nErrors++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {arst_n, hsel, hwrite, htrans, haddr, hwdata, faultReq, coastOk, fastOk, travDone} = '0;
    hsize = 3'b010;
    faultNum = 8'h00;
    stopDelay = 4'h1;
    nErrors = 0;
    checked = 0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    void'($urandom(32'h59a76f20));
    chkReg(`AOI_OFS_CFG, 32'hFFFF_FFFF, 32'h0000_6400);
    chkReg(`AOI_OFS_ALARM, 32'h0000_003F, 32'h0000_0001);
    chkReg(`AOI_OFS_IRQSTAT, 32'h0000_003F, 32'h0000_0001);
    chkReg(`AOI_OFS_STATUS, 32'h0000_0006, 32'h0000_0000);
    chkReg(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset done");
    wr(`AOI_OFS_IRQSTAT, 32'h0000_003F);
    wr(`AOI_OFS_IRQMASK, 32'h0000_003F);
    wr(`AOI_OFS_CTRL, 32'h0000_0020);
    repeat (2) @(posedge sys_clk);
    chkReg(`AOI_OFS_ALARM, 32'h0000_003F, 32'h0000_0003);
    chkPin(6'b000001, 6'b010011);
    wr(`AOI_OFS_IRQSTAT, 32'h0000_003F);
    @(posedge sys_clk);
    chkPin(6'b000000, 6'b000001);
    chkReg(`AOI_OFS_CTRL, 32'h0000_003F, 32'h0000_0000);
    $display("test refused start done");
    coastOk <= 1'b1;
    fastOk <= 1'b1;
    axisM = 1 + ($urandom % 255);
    wr(`AOI_OFS_CFG, 32'h0000_0200 | axisM);
    wr(`AOI_OFS_CTRL, 32'h0000_000F);
    chkReg(`AOI_OFS_STATUS, 32'h0000_0006, expInop(15, 1, 0, axisM, 1));
    chkReg(`AOI_OFS_ALARM, 32'h0000_003F, 32'h0000_0000);
    chkPin(6'b000010, 6'b000010);
    // a finished traverse goes back to idle with pulses still on
    wr(`AOI_OFS_CTRL, 32'h0000_002F);
    travDone <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chkPin(6'b110010, 6'b111110);
    repeat (2) @(posedge sys_clk);
    chkPin(6'b100010, 6'b111110);
    travDone <= 1'b0;
    $display("test bring-up done");
    // each stop cause but axis removal in turn, the last one two causes together
    for (int k = 0; k < 8; k++) begin
      faultNum <= 8'($urandom);
      stopDelay <= 4'(1 + $urandom % 8);
      wr(`AOI_OFS_CTRL, 32'h0000_002F);
      repeat (2) @(posedge sys_clk);
      chkPin(6'b110010, 6'b111110);
      wr(`AOI_OFS_CTRL, ctTab[k]);
      coastOk <= (k != 4);
      fastOk <= (k != 5);
      faultReq <= (k == 6);
      repeat (6) @(posedge sys_clk);
      chkPin({dmTab[k] != 0, 1'b0, 2'(dmTab[k]), 2'b00}, 6'b101100);
      if (k == 0) begin
        repeat (8) @(posedge sys_clk);
        chkPin(6'b100000, 6'b100000);
      end
      repeat (30) @(posedge sys_clk);
      chkPin({5'b00000, alTab[k] != 0}, 6'b100001);
      chkReg(`AOI_OFS_ALARM, 32'h0000_003F, alTab[k]);
      if (k == 6) begin
        chkReg(`AOI_OFS_STATUS, 32'h0000_FF06, {16'h0000, faultNum, 8'h02});
        wr(`AOI_OFS_CTRL, 32'h0000_001F);
        chkReg(`AOI_OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        faultReq <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(`AOI_OFS_CTRL, 32'h0000_001F);
        chkReg(`AOI_OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
      end
      wr(`AOI_OFS_IRQSTAT, 32'h0000_003F);
      @(posedge sys_clk);
      chkPin(6'b000000, 6'b000001);
      coastOk <= 1'b1;
      fastOk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr(`AOI_OFS_CTRL, 32'h0000_000F);
      chkReg(`AOI_OFS_STATUS, 4, expInop(15, 1, 0, axisM, k == 0 || k == 7));
      wr(`AOI_OFS_CTRL, 32'h0000_000E);
      wr(`AOI_OFS_CTRL, 32'h0000_000F);
      chkReg(`AOI_OFS_STATUS, 4, expInop(15, 1, 0, axisM, 1));
      chkReg(`AOI_OFS_ALARM, 32'h0000_003E, 32'h0000_0000);
      $display("test stop cause %0d done", k);
    end
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
